// >>> logic/charger_option_control_bank.v
// Charger option control bank: option one low bits and option two
// Function
// RULE_01: Ship bit set pulls battery sense low for 140 ms, then self-clears.
// RULE_02: Auto-wakeup with low battery enables 128 mA charge for up to 30 minutes.
// RULE_03: Battery above minimum during wakeup stops charge and clears wakeup bit.
// RULE_04: Overload time field bits 15-14 selects 1, 2, 10, 20 ms; reset 00.
// RULE_05: Bit 13 enables input overshoot trigger; bit 12 system undershoot trigger.
// RULE_06: Both trigger enables zero keeps peak power mode off.
// RULE_07: Adapter removal clears both peak power trigger enables.
// RULE_08: Bit 11 shows overload cycle; writing zero ends it.
// RULE_09: Bit 10 shows relaxation cycle; writing zero ends it.
// RULE_10: Cycle time field bits 9-8 selects 5, 10, 20, 40 ms; reset 10.
// RULE_11: Overload time not shorter than cycle time skips relaxation.
// RULE_12: Bit 7 chooses register-only or lower of pin and register limit.
// RULE_13: Bit 6 makes current monitor report discharge (0) or charge (1).
// RULE_14: Bit 5 low-switch trip threshold 300 mV or 500 mV.
// RULE_15: Bit 4 input sense trip threshold 150 mV or 280 mV.
// RULE_16: Bit 3 input overcurrent disables converter after 100 us blanking.
// RULE_17: Bit 2 input overcurrent level 125% or 200% of critical current.
// RULE_18: Bit 1 discharge overcurrent disables converter on detection.
// RULE_19: Bit 0 discharge overcurrent level 125% or 200% of discharge limit.
// RULE_20: Auto-wakeup bit resets to one, ship bit resets to zero.
// RULE_21: Intervals come from timebase counters; self-cleared bits read back cleared.
`timescale 1ns/1ps
`default_nettype none
`include "charger_option_consts.vh"

module charger_option_control_bank #(
	parameter [6:0] DEV_ADDR = 7'h09,
	parameter integer MS_CYCLES = `MS_CYCLES,
	parameter integer SHIP_CYCLES = `SHIP_WINDOW_CYCLES,
	parameter integer WAKE_MS = `WAKE_LIMIT_MS
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// SMBus pins
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_drive_n,
	// Analog status inputs
	input wire adapter_present,
	input wire battery_below_min,
	input wire input_overshoot,
	input wire sys_undershoot,
	input wire input_overcurrent_det,
	input wire discharge_overcurrent_det,
	// Shipping and wakeup controls
	output wire battery_sense_neg_pulldown,
	output wire wake_charge_en,
	// Peak power controls
	output wire [1:0] peak_overload_time_sel,
	output wire [1:0] peak_cycle_time_sel,
	output wire peak_overload_active,
	output wire peak_relax_active,
	// Analog selections
	output wire pin_limit_select,
	output wire monitor_direction_sel,
	output wire low_switch_trip_sel,
	output wire input_sense_trip_sel,
	output wire input_overcurrent_level_sel,
	output wire discharge_overcurrent_level_sel,
	output wire converter_disable
);

	localparam [2:0] PK_IDLE = 3'b001;
	localparam [2:0] PK_OVERLOAD = 3'b010;
	localparam [2:0] PK_RELAX = 3'b100;
	localparam integer BLANK_LAST = `INPUT_OC_BLANK_CYCLES - 1;
	localparam integer SHIP_LAST = SHIP_CYCLES - 1;
	localparam integer WAKE_LAST = WAKE_MS - 1;
	localparam integer MS_LAST = MS_CYCLES - 1;
	localparam [1:0] OPT1_RESET = `CHARGE_OPTION_ONE_RESET;

	function [5:0] overload_ms;
		input [1:0] code;
		begin
			case (code)
			2'h0: overload_ms = `OVERLOAD_MS_0;
			2'h1: overload_ms = `OVERLOAD_MS_1;
			2'h2: overload_ms = `OVERLOAD_MS_2;
			default: overload_ms = `OVERLOAD_MS_3;
			endcase
		end
	endfunction

	function [5:0] cycle_ms;
		input [1:0] code;
		begin
			case (code)
			2'h0: cycle_ms = `CYCLE_MS_0;
			2'h1: cycle_ms = `CYCLE_MS_1;
			2'h2: cycle_ms = `CYCLE_MS_2;
			default: cycle_ms = `CYCLE_MS_3;
			endcase
		end
	endfunction

	wire wr_en;
	wire [7:0] cmd;
	wire [15:0] wr_data;
	reg [15:0] rd_data;
	wire [5:0] raw_in;
	reg [5:0] sync_m, sync_s;
	reg adapter_p;
	reg ship, auto_wake, wake_on, wake_expired;
	reg [15:0] opt2;
	reg [2:0] pk_state;
	reg [5:0] pk_cnt;
	reg [15:0] ms_div;
	reg ms_tick;
	reg [21:0] ship_cnt;
	reg [20:0] wake_cnt;
	reg [11:0] blank_cnt;
	reg blank_done, conv_off;

	smbus_target #(
		.DEV_ADDR(DEV_ADDR)
	) u_target (
		.core_clk(core_clk),
		.reset(reset),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_drive_n(sda_drive_n),
		.wr_en(wr_en),
		.cmd(cmd),
		.wr_data(wr_data),
		.rd_data(rd_data)
	);

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;

	// Analog levels are asynchronous to the core clock
	assign raw_in = {adapter_present, battery_below_min, input_overshoot,
		sys_undershoot, input_overcurrent_det, discharge_overcurrent_det};
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
			always @(posedge core_clk) begin
				if (reset) begin
					sync_m[gi] <= 1'b0;
					sync_s[gi] <= 1'b0;
				end else begin
					sync_m[gi] <= raw_in[gi];
					sync_s[gi] <= sync_m[gi];
				end
			end
		end
	endgenerate
	wire adapter_s = sync_s[5];
	wire below_s = sync_s[4];
	wire overshoot_s = sync_s[3];
	wire undershoot_s = sync_s[2];
	wire input_oc_s = sync_s[1];
	wire discharge_oc_s = sync_s[0];

	wire wr_one = wr_en && cmd == `REG_CHARGE_OPTION_ONE;
	wire wr_two = wr_en && cmd == `REG_CHARGE_OPTION_TWO;
	wire [5:0] ovl_ms = overload_ms(opt2[`FLD_OVERLOAD_TIME_HI:
		`FLD_OVERLOAD_TIME_LO]); // RULE_04
	wire [5:0] cyc_ms = cycle_ms(opt2[`FLD_CYCLE_TIME_HI:
		`FLD_CYCLE_TIME_LO]); // RULE_10
	wire [5:0] relax_ms = cyc_ms - ovl_ms;
	wire has_relax = cyc_ms > ovl_ms;
	wire pk_enabled = opt2[`BIT_PEAK_ON_INPUT] | opt2[`BIT_PEAK_ON_SYS];
	wire pk_trigger = (opt2[`BIT_PEAK_ON_INPUT] & overshoot_s) |
		(opt2[`BIT_PEAK_ON_SYS] & undershoot_s); // RULE_05
	wire ship_done = ship && ship_cnt == SHIP_LAST[21:0];
	wire wake_done = wake_on && ms_tick && wake_cnt == WAKE_LAST[20:0];

	// Millisecond timebase
	always @(posedge core_clk) begin
		if (reset) begin
			ms_div <= 16'h0000;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= ms_div == MS_LAST[15:0]; // RULE_21
			ms_div <= (ms_div == MS_LAST[15:0]) ? 16'h0000 :
				ms_div + 16'h0001;
		end
	end

	// Option one: shipping discharge and auto-wakeup
	always @(posedge core_clk) begin
		if (reset) begin
			ship <= OPT1_RESET[`BIT_SHIP_DISCHARGE]; // RULE_20
			auto_wake <= OPT1_RESET[`BIT_AUTO_WAKEUP]; // RULE_20
			ship_cnt <= 22'h000000;
			wake_on <= 1'b0;
			wake_expired <= 1'b0;
			wake_cnt <= 21'h000000;
		end else begin
			ship_cnt <= (ship && !ship_done) ? ship_cnt + 22'h000001 :
				22'h000000; // RULE_01
			if (ship_done)
				ship <= 1'b0; // RULE_01
			if (wake_on && !below_s)
				auto_wake <= 1'b0; // RULE_03
			// Host write comes last so a set beats a same-cycle clear
			if (wr_one) begin
				ship <= wr_data[`BIT_SHIP_DISCHARGE];
				auto_wake <= wr_data[`BIT_AUTO_WAKEUP];
			end
			wake_on <= auto_wake && below_s && !wake_expired &&
				!wake_done && !(wr_one && !wr_data[`BIT_AUTO_WAKEUP]); // RULE_02
			if (!wake_on)
				wake_cnt <= 21'h000000;
			else if (ms_tick)
				wake_cnt <= wake_cnt + 21'h000001; // RULE_02
			// Expiry beats a same-cycle rewrite, then holds until the next
			if (wake_done)
				wake_expired <= 1'b1; // RULE_02
			else if (wr_one || !auto_wake)
				wake_expired <= 1'b0;
		end
	end

	// Option two storage
	always @(posedge core_clk) begin
		if (reset) begin
			opt2 <= `CHARGE_OPTION_TWO_RESET; // RULE_04 RULE_10
			adapter_p <= 1'b0;
		end else begin
			adapter_p <= adapter_s;
			if (wr_two) begin
				opt2 <= wr_data;
				opt2[`BIT_OVERLOAD_STAT] <= 1'b0;
				opt2[`BIT_RELAX_STAT] <= 1'b0;
			end
			// Removal wins over a host write in the same cycle
			if (adapter_p && !adapter_s) begin
				opt2[`BIT_PEAK_ON_INPUT] <= 1'b0; // RULE_07
				opt2[`BIT_PEAK_ON_SYS] <= 1'b0; // RULE_07
			end
		end
	end

	// Peak power overload and relax sequencer
	always @(posedge core_clk) begin
		if (reset) begin
			pk_state <= PK_IDLE;
			pk_cnt <= 6'h00;
		end else begin
			case (pk_state)
			PK_IDLE: begin
				pk_cnt <= 6'h00;
				if (pk_enabled && pk_trigger)
					pk_state <= PK_OVERLOAD;
			end
			PK_OVERLOAD: begin
				if (!pk_enabled) begin
					pk_state <= PK_IDLE; // RULE_06
				end else if (wr_two && !wr_data[`BIT_OVERLOAD_STAT]) begin
					pk_state <= PK_IDLE; // RULE_08
				end else if (ms_tick) begin
					pk_cnt <= pk_cnt + 6'h01;
					if (pk_cnt + 6'h01 >= ovl_ms) begin
						pk_cnt <= 6'h00;
						pk_state <= has_relax ? PK_RELAX : PK_IDLE; // RULE_11
					end
				end
			end
			PK_RELAX: begin
				if (!pk_enabled) begin
					pk_state <= PK_IDLE; // RULE_06
				end else if (wr_two && !wr_data[`BIT_RELAX_STAT]) begin
					pk_state <= PK_IDLE; // RULE_09
				end else if (ms_tick) begin
					pk_cnt <= pk_cnt + 6'h01;
					if (pk_cnt + 6'h01 >= relax_ms)
						pk_state <= PK_IDLE;
				end
			end
			default: pk_state <= PK_IDLE;
			endcase
		end
	end

	// Overcurrent protection
	always @(posedge core_clk) begin
		if (reset) begin
			blank_cnt <= 12'h000;
			blank_done <= 1'b0;
			conv_off <= 1'b0;
		end else begin
			if (!(opt2[`BIT_INPUT_OC_EN] && input_oc_s)) begin
				blank_cnt <= 12'h000;
				blank_done <= 1'b0;
			end else if (blank_cnt == BLANK_LAST[11:0]) begin
				blank_done <= 1'b1; // RULE_16
			end else begin
				blank_cnt <= blank_cnt + 12'h001;
			end
			conv_off <= (blank_done && opt2[`BIT_INPUT_OC_EN] &&
				input_oc_s) || // RULE_16
				(opt2[`BIT_DISCHARGE_OC_EN] && discharge_oc_s); // RULE_18
		end
	end

	// Read data; status bits come from the live sequencer
	always @* begin
		case (cmd)
		`REG_CHARGE_OPTION_ONE:
			rd_data = {14'h0000, ship, auto_wake}; // RULE_21
		`REG_CHARGE_OPTION_TWO: begin
			rd_data = opt2;
			rd_data[`BIT_OVERLOAD_STAT] = pk_state[1]; // RULE_08
			rd_data[`BIT_RELAX_STAT] = pk_state[2]; // RULE_09
		end
		default: rd_data = 16'h0000;
		endcase
	end

	assign battery_sense_neg_pulldown = ship; // RULE_01
	assign wake_charge_en = wake_on; // RULE_02
	assign peak_overload_time_sel = opt2[`FLD_OVERLOAD_TIME_HI:
		`FLD_OVERLOAD_TIME_LO];
	assign peak_cycle_time_sel = opt2[`FLD_CYCLE_TIME_HI:`FLD_CYCLE_TIME_LO];
	assign peak_overload_active = pk_state[1]; // RULE_08
	assign peak_relax_active = pk_state[2]; // RULE_09
	assign pin_limit_select = opt2[`BIT_PIN_LIMIT]; // RULE_12
	assign monitor_direction_sel = opt2[`BIT_MONITOR_DIR]; // RULE_13
	assign low_switch_trip_sel = opt2[`BIT_LOW_SWITCH_TRIP]; // RULE_14
	assign input_sense_trip_sel = opt2[`BIT_INPUT_SENSE_TRIP]; // RULE_15
	assign input_overcurrent_level_sel = opt2[`BIT_INPUT_OC_LEVEL]; // RULE_17
	assign discharge_overcurrent_level_sel =
		opt2[`BIT_DISCHARGE_OC_LEVEL]; // RULE_19
	assign converter_disable = conv_off;

endmodule

`default_nettype wire

// >>> shared/charger_option_consts.vh
// Constants for the charger option register bank
`ifndef CHARGER_OPTION_CONSTS_VH
`define CHARGER_OPTION_CONSTS_VH

// Core clock and timebase
`define CORE_CLK_HZ 25000000
`define MS_CYCLES (`CORE_CLK_HZ / 1000)
`define SHIP_WINDOW_MS 140
`define SHIP_WINDOW_CYCLES (`SHIP_WINDOW_MS * `MS_CYCLES)
`define WAKE_LIMIT_MIN 30
`define WAKE_LIMIT_MS (`WAKE_LIMIT_MIN * 60000)
`define INPUT_OC_BLANK_US 100
`define INPUT_OC_BLANK_CYCLES ((`CORE_CLK_HZ / 1000000) * `INPUT_OC_BLANK_US)

// Register commands
`define REG_CHARGE_OPTION_ONE 8'h30
`define REG_CHARGE_OPTION_TWO 8'h31

// Reset values
`define CHARGE_OPTION_ONE_RESET 2'h1
`define CHARGE_OPTION_TWO_RESET 16'h02b7

// Option one field positions
`define BIT_SHIP_DISCHARGE 1
`define BIT_AUTO_WAKEUP 0

// Option two field positions
`define FLD_OVERLOAD_TIME_HI 15
`define FLD_OVERLOAD_TIME_LO 14
`define BIT_PEAK_ON_INPUT 13
`define BIT_PEAK_ON_SYS 12
`define BIT_OVERLOAD_STAT 11
`define BIT_RELAX_STAT 10
`define FLD_CYCLE_TIME_HI 9
`define FLD_CYCLE_TIME_LO 8
`define BIT_PIN_LIMIT 7
`define BIT_MONITOR_DIR 6
`define BIT_LOW_SWITCH_TRIP 5
`define BIT_INPUT_SENSE_TRIP 4
`define BIT_INPUT_OC_EN 3
`define BIT_INPUT_OC_LEVEL 2
`define BIT_DISCHARGE_OC_EN 1
`define BIT_DISCHARGE_OC_LEVEL 0

// Peak power timings in ms per code
`define OVERLOAD_MS_0 6'd1
`define OVERLOAD_MS_1 6'd2
`define OVERLOAD_MS_2 6'd10
`define OVERLOAD_MS_3 6'd20
`define CYCLE_MS_0 6'd5
`define CYCLE_MS_1 6'd10
`define CYCLE_MS_2 6'd20
`define CYCLE_MS_3 6'd40

`endif

// >>> logic/smbus_target.v
// SMBus word-access target sampled by the core clock
`timescale 1ns/1ps
`default_nettype none

module smbus_target #(
	parameter [6:0] DEV_ADDR = 7'h09
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Bus pins
	input wire scl_in,
	input wire sda_in,
	output reg sda_drive_n,
	// Register side
	output reg wr_en,
	output reg [7:0] cmd,
	output reg [15:0] wr_data,
	input wire [15:0] rd_data
);

	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_RECV = 5'b00010;
	localparam [4:0] ST_ACK = 5'b00100;
	localparam [4:0] ST_SEND = 5'b01000;
	localparam [4:0] ST_MACK = 5'b10000;

	reg scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
	reg [4:0] state;
	reg [3:0] bitcnt;
	reg [7:0] shift;
	reg [7:0] hold;
	reg [1:0] idx;
	reg is_read, high_sent, master_ack;
	wire start = scl_s & scl_p & sda_p & ~sda_s;
	wire stop = scl_s & scl_p & ~sda_p & sda_s;
	wire rise = scl_s & ~scl_p;
	wire fall = ~scl_s & scl_p;

	always @(posedge core_clk) begin
		if (reset) begin
			{scl_m, scl_s, scl_p, sda_m, sda_s, sda_p} <= 6'h3f;
			state <= ST_IDLE;
			bitcnt <= 4'h0;
			shift <= 8'h00;
			hold <= 8'h00;
			idx <= 2'h0;
			is_read <= 1'b0;
			high_sent <= 1'b0;
			master_ack <= 1'b0;
			sda_drive_n <= 1'b1;
			wr_en <= 1'b0;
			cmd <= 8'h00;
			wr_data <= 16'h0000;
		end else begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			scl_p <= scl_s;
			sda_m <= sda_in;
			sda_s <= sda_m;
			sda_p <= sda_s;
			wr_en <= 1'b0;
			if (start) begin
				state <= ST_RECV;
				bitcnt <= 4'h0;
				idx <= 2'h0;
				sda_drive_n <= 1'b1;
			end else if (stop) begin
				state <= ST_IDLE;
				sda_drive_n <= 1'b1;
			end else begin
				case (state)
				ST_IDLE: begin
					sda_drive_n <= 1'b1;
				end
				ST_RECV: begin
					if (rise) begin
						shift <= {shift[6:0], sda_s};
						bitcnt <= bitcnt + 4'h1;
					end else if (fall && bitcnt == 4'h8) begin
						state <= ST_ACK;
						sda_drive_n <= 1'b0;
						bitcnt <= 4'h0;
						case (idx)
						2'h0: begin
							is_read <= shift[0];
							if (shift[7:1] != DEV_ADDR) begin
								state <= ST_IDLE;
								sda_drive_n <= 1'b1;
							end
						end
						2'h1: cmd <= shift;
						2'h2: hold <= shift;
						default: begin
							wr_en <= 1'b1;
							wr_data <= {shift, hold};
						end
						endcase
					end
				end
				ST_ACK: begin
					if (fall) begin
						if (is_read && idx == 2'h0) begin
							// Both bytes captured now so a word reads coherently
							state <= ST_SEND;
							shift <= rd_data[7:0];
							hold <= rd_data[15:8];
							high_sent <= 1'b0;
							sda_drive_n <= rd_data[7];
						end else if (idx == 2'h3) begin
							state <= ST_IDLE;
							sda_drive_n <= 1'b1;
						end else begin
							state <= ST_RECV;
							sda_drive_n <= 1'b1;
							idx <= idx + 2'h1;
						end
					end
				end
				ST_SEND: begin
					if (fall) begin
						if (bitcnt == 4'h7) begin
							state <= ST_MACK;
							sda_drive_n <= 1'b1;
							bitcnt <= 4'h0;
						end else begin
							shift <= {shift[6:0], 1'b0};
							sda_drive_n <= shift[6];
							bitcnt <= bitcnt + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (rise) begin
						master_ack <= ~sda_s;
					end else if (fall) begin
						if (master_ack && !high_sent) begin
							state <= ST_SEND;
							high_sent <= 1'b1;
							shift <= hold;
							sda_drive_n <= hold[7];
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
					sda_drive_n <= 1'b1;
				end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// >>> dv/charger_option_checker_sva.sv
// Port checker for the charger option control bank
`timescale 1ns/1ps
`default_nettype none
module charger_option_checker #(
	parameter integer MS_CYCLES = 10,
	parameter integer SHIP_CYCLES = 50,
	parameter integer WAKE_MS = 20
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Status inputs
	input wire adapter_present,
	input wire battery_below_min,
	input wire input_overcurrent_det,
	input wire discharge_overcurrent_det,
	// Controls
	input wire battery_sense_neg_pulldown,
	input wire wake_charge_en,
	input wire [1:0] peak_overload_time_sel,
	input wire [1:0] peak_cycle_time_sel,
	input wire peak_overload_active,
	input wire peak_relax_active,
	input wire pin_limit_select,
	input wire monitor_direction_sel,
	input wire low_switch_trip_sel,
	input wire input_sense_trip_sel,
	input wire input_overcurrent_level_sel,
	input wire discharge_overcurrent_level_sel,
	input wire converter_disable
);
	localparam int BLANK = 2500;
	localparam logic [23:0] OVL_TAB = {6'h14, 6'h0a, 6'h02, 6'h01};
	localparam logic [23:0] CYC_TAB = {6'h28, 6'h14, 6'h0a, 6'h05};
	int ship_n, wake_n, ovl_n, rlx_n, in_n;
	logic [3:0] dis_hist;
	logic [5:0] ovl_ms, cyc_ms;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	assign ovl_ms = OVL_TAB[peak_overload_time_sel * 6 +: 6];
	assign cyc_ms = CYC_TAB[peak_cycle_time_sel * 6 +: 6];
	// Run lengths of each level but discharge, cleared whenever the level drops; discharge keeps its last four samples
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ship_n <= 0;
			wake_n <= 0;
			ovl_n <= 0;
			rlx_n <= 0;
			in_n <= 0;
			dis_hist <= 4'h0;
		end else begin
			ship_n <= battery_sense_neg_pulldown ? ship_n + 1 : 0;
			wake_n <= wake_charge_en ? wake_n + 1 : 0;
			ovl_n <= peak_overload_active ? ovl_n + 1 : 0;
			rlx_n <= peak_relax_active ? rlx_n + 1 : 0;
			in_n <= input_overcurrent_det ? in_n + 1 : 0;
			dis_hist <= {dis_hist[2:0], discharge_overcurrent_det};
		end
	end
	reset_defaults_a: assert property (
		$past(reset) |-> peak_overload_time_sel == 2'h0 &&
		peak_cycle_time_sel == 2'h2 && pin_limit_select &&
		!monitor_direction_sel && low_switch_trip_sel &&
		input_sense_trip_sel && input_overcurrent_level_sel &&
		discharge_overcurrent_level_sel && !battery_sense_neg_pulldown)
		else $error("option outputs differ from reset values");
	ship_window_a: assert property (
		$fell(battery_sense_neg_pulldown) |-> ship_n >= SHIP_CYCLES - 1)
		else $error("ship pulldown ended early");
	ship_limit_a: assert property (
		battery_sense_neg_pulldown |-> ship_n <= SHIP_CYCLES + 1)
		else $error("ship pulldown overran its window");
	wake_limit_a: assert property (
		wake_charge_en |-> wake_n <= WAKE_MS * MS_CYCLES + 4)
		else $error("wakeup charge overran its limit");
	wake_stop_a: assert property (
		!battery_below_min [*6] |-> !wake_charge_en)
		else $error("wakeup charge kept with battery above minimum");
	peak_adapter_a: assert property (
		!adapter_present [*5] |-> !$rose(peak_overload_active))
		else $error("peak overload started without adapter");
	overload_len_a: assert property (
		peak_overload_active |-> ovl_n <= ovl_ms * MS_CYCLES + 2)
		else $error("overload phase too long");
	relax_len_a: assert property (
		peak_relax_active |-> rlx_n <= (cyc_ms - ovl_ms) * MS_CYCLES + 2)
		else $error("relax phase too long");
	relax_skip_a: assert property (
		$rose(peak_relax_active) |-> cyc_ms > ovl_ms)
		else $error("relax entered with overload not shorter");
	input_blank_a: assert property (
		$rose(converter_disable) |-> in_n >= BLANK || dis_hist != 4'h0)
		else $error("converter disabled inside blanking time");
endmodule
bind charger_option_control_bank charger_option_checker #(
	.MS_CYCLES(MS_CYCLES), .SHIP_CYCLES(SHIP_CYCLES), .WAKE_MS(WAKE_MS)
) u_checker (
	.core_clk, .reset, .adapter_present, .battery_below_min,
	.input_overcurrent_det, .discharge_overcurrent_det,
	.battery_sense_neg_pulldown, .wake_charge_en, .peak_overload_time_sel,
	.peak_cycle_time_sel, .peak_overload_active, .peak_relax_active,
	.pin_limit_select, .monitor_direction_sel, .low_switch_trip_sel,
	.input_sense_trip_sel, .input_overcurrent_level_sel,
	.discharge_overcurrent_level_sel, .converter_disable
);
`default_nettype wire

// >>> dv/smbus_host_model.sv
// Behavioural SMBus host issuing word writes and word reads
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model #(
	parameter [6:0] ADDR = 7'h09
) (
	// Bus pins; pull high means the host sinks SDA
	output logic scl,
	output logic pull,
	input wire logic sda
);
	// Clock stands high between frames
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task automatic bit_out(input logic b);
		scl = 1'b0;
		#80 pull = !b;
		#80 scl = 1'b1;
		#160;
	endtask
	// Sample midway through the high phase, after the target's answer settled
	task automatic bit_in(output logic b);
		scl = 1'b0;
		#80 pull = 1'b0;
		#80 scl = 1'b1;
		#80 b = sda;
		#80;
	endtask
	task automatic start();
		scl = 1'b0;
		#80 pull = 1'b0;
		#80 scl = 1'b1;
		#80 pull = 1'b1;
		#80;
	endtask
	task automatic stop();
		scl = 1'b0;
		#80 pull = 1'b1;
		#80 scl = 1'b1;
		#80 pull = 1'b0;
		#160;
	endtask
	task automatic byte_out(input logic [7:0] v, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_out(v[i]);
		bit_in(a);
		ack = !a;
	endtask
	task automatic byte_in(input logic last, output logic [7:0] v);
		for (int i = 7; i >= 0; i--)
			bit_in(v[i]);
		bit_out(last);
	endtask
	task automatic write_word(input logic [7:0] cmd, input logic [15:0] d,
		output logic ok);
		logic a0, a1, a2, a3;
		start();
		byte_out({ADDR, 1'b0}, a0);
		byte_out(cmd, a1);
		byte_out(d[7:0], a2);
		byte_out(d[15:8], a3);
		stop();
		ok = a0 && a1 && a2 && a3;
	endtask
	task automatic read_word(input logic [7:0] cmd, output logic [15:0] d,
		output logic ok);
		logic a0, a1, a2;
		start();
		byte_out({ADDR, 1'b0}, a0);
		byte_out(cmd, a1);
		start();
		byte_out({ADDR, 1'b1}, a2);
		byte_in(1'b0, d[7:0]);
		byte_in(1'b1, d[15:8]);
		stop();
		ok = a0 && a1 && a2;
	endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking testbench for the charger option control bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	errors++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
	localparam int MS = 20;
	localparam int WAKE = 20;
	int errors = 0;
	int samples_checked = 0;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic adapter_present = 1'b1;
	logic battery_below_min = 1'b0;
	logic input_overshoot = 1'b0;
	logic sys_undershoot = 1'b0;
	logic input_overcurrent_det = 1'b0;
	logic discharge_overcurrent_det = 1'b0;
	logic ok;
	logic [15:0] rdata;
	wire scl, pull, sda_drive_n, battery_sense_neg_pulldown, wake_charge_en;
	wire peak_overload_active, peak_relax_active, converter_disable;
	wire [1:0] peak_overload_time_sel, peak_cycle_time_sel;
	wire [5:0] selects;
	// Open drain: either side sinking wins, else the pull-up
	wire sda = !(pull || !sda_drive_n);
	charger_option_control_bank #(.MS_CYCLES(MS), .SHIP_CYCLES(50),
		.WAKE_MS(WAKE)) u_charger_option_control_bank (
		.core_clk, .reset, .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_drive_n, .adapter_present, .battery_below_min,
		.input_overshoot, .sys_undershoot, .input_overcurrent_det,
		.discharge_overcurrent_det, .battery_sense_neg_pulldown,
		.wake_charge_en, .peak_overload_time_sel, .peak_cycle_time_sel,
		.peak_overload_active, .peak_relax_active,
		.pin_limit_select(selects[5]), .monitor_direction_sel(selects[4]),
		.low_switch_trip_sel(selects[3]), .input_sense_trip_sel(selects[2]),
		.input_overcurrent_level_sel(selects[1]),
		.discharge_overcurrent_level_sel(selects[0]), .converter_disable);
	smbus_host_model host (.scl(scl), .pull(pull), .sda(sda));
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
		host.write_word(cmd, d, ok);
		`CHK("write_ack", 1'b1, ok)
	endtask
	task automatic rd(input logic [7:0] cmd, input logic [15:0] e,
		input string nm);
		host.read_word(cmd, rdata, ok);
		`CHK(nm, e, rdata)
	endtask
	task automatic pulse(input int which);
		if (which == 0)
			input_overshoot = 1'b1;
		else
			sys_undershoot = 1'b1;
		repeat (4) @(negedge core_clk);
		input_overshoot = 1'b0;
		sys_undershoot = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask
	task automatic t_reset();
		rd(8'h31, 16'h02b7, "opt_two_reset");
		rd(8'h30, 16'h0001, "opt_one_reset");
		rd(8'h3f, 16'h0000, "unmapped");
	endtask
	// Status bits written as one must read back zero
	task automatic t_fields();
		logic [7:0] lo;
		for (int i = 0; i < 4; i++) begin
			lo = i[0] ? 8'hb7 : 8'h48;
			wr(8'h31, {i[1:0], 4'hf, i[1:0], lo});
			rd(8'h31, {i[1:0], 4'hc, i[1:0], lo}, "opt_two");
			`CHK("overload_sel", i[1:0], peak_overload_time_sel)
			`CHK("cycle_sel", i[1:0], peak_cycle_time_sel)
			`CHK("sel_hi", lo[7:4], selects[5:2])
			`CHK("sel_lo", {lo[2], lo[0]}, selects[1:0])
		end
	endtask
	task automatic t_ship();
		int n;
		wr(8'h30, 16'h0003);
		`CHK("ship_on", 1'b1, battery_sense_neg_pulldown)
		for (n = 0; n < 80 && battery_sense_neg_pulldown; n++)
			@(negedge core_clk);
		`CHK("ship_off", 1'b0, battery_sense_neg_pulldown)
		rd(8'h30, 16'h0001, "ship_cleared");
	endtask
	task automatic t_wake();
		battery_below_min = 1'b1;
		repeat (8) @(negedge core_clk);
		`CHK("wake_on", 1'b1, wake_charge_en)
		repeat (WAKE * MS + 20) @(negedge core_clk);
		`CHK("wake_expired", 1'b0, wake_charge_en)
		wr(8'h30, 16'h0001);
		`CHK("wake_again", 1'b1, wake_charge_en)
		battery_below_min = 1'b0;
		repeat (8) @(negedge core_clk);
		`CHK("wake_stop", 1'b0, wake_charge_en)
		rd(8'h30, 16'h0000, "auto_cleared");
	endtask
	// Long phases so that a host write lands inside each one
	task automatic t_peak();
		int n;
		wr(8'h31, 16'hf3b7);
		pulse(0);
		`CHK("ovl_start", 1'b1, peak_overload_active)
		wr(8'h31, 16'hf3b7);
		`CHK("ovl_end", 2'b00, {peak_overload_active, peak_relax_active})
		pulse(1);
		for (n = 0; n < 500 && !peak_relax_active; n++)
			@(negedge core_clk);
		`CHK("relax_start", 1'b1, peak_relax_active)
		wr(8'h31, 16'hf3b7);
		`CHK("relax_end", 2'b00, {peak_overload_active, peak_relax_active})
		wr(8'h31, 16'hd0b7);
		pulse(1);
		for (n = 0; n < 500 && peak_overload_active; n++)
			@(negedge core_clk);
		repeat (4) @(negedge core_clk);
		`CHK("no_relax", 2'b00, {peak_overload_active, peak_relax_active})
		wr(8'h31, 16'h00b7);
		pulse(0);
		pulse(1);
		`CHK("peak_off", 1'b0, peak_overload_active)
		wr(8'h31, 16'h30b7);
		adapter_present = 1'b0;
		repeat (8) @(negedge core_clk);
		rd(8'h31, 16'h00b7, "adapter_clear");
		pulse(0);
		`CHK("peak_no_adapter", 1'b0, peak_overload_active)
		adapter_present = 1'b1;
	endtask
	task automatic t_oc();
		wr(8'h31, 16'h00bf);
		input_overcurrent_det = 1'b1;
		repeat (2400) @(negedge core_clk);
		`CHK("blanking", 1'b0, converter_disable)
		repeat (110) @(negedge core_clk);
		`CHK("input_trip", 1'b1, converter_disable)
		input_overcurrent_det = 1'b0;
		repeat (6) @(negedge core_clk);
		`CHK("input_clear", 1'b0, converter_disable)
		discharge_overcurrent_det = 1'b1;
		repeat (6) @(negedge core_clk);
		`CHK("dis_trip", 1'b1, converter_disable)
		discharge_overcurrent_det = 1'b0;
		wr(8'h31, 16'h00b5);
		discharge_overcurrent_det = 1'b1;
		repeat (6) @(negedge core_clk);
		`CHK("dis_off", 1'b0, converter_disable)
		discharge_overcurrent_det = 1'b0;
	endtask
	initial begin
		repeat (6) @(negedge core_clk);
		reset = 1'b0;
		repeat (3) @(negedge core_clk);
		t_reset();
		t_fields();
		t_ship();
		t_wake();
		t_peak();
		t_oc();
		close_out();
	end
	initial begin
		#2000000;
		errors++;
		close_out();
	end
endmodule
`default_nettype wire
